// File: shared/nvm_consts.svh
`ifndef NVM_CONSTS_SVH
`define NVM_CONSTS_SVH
// ***************************************************
// device i/o register addresses
// ***************************************************
`define NVM_IO_CONTROL 6'h1c
`define NVM_IO_DATA 6'h1d
`define NVM_IO_ADDR_LOW 6'h1e
`define NVM_IO_ADDR_HIGH 6'h1f
// control register bit positions
`define NVM_CTL_RIE 3
`define NVM_CTL_ARM 2
`define NVM_CTL_WS 1
`define NVM_CTL_RS 0
// ***************************************************
// timing, in clock cycles unless named otherwise
// ***************************************************
`define NVM_STALL_READ 3'h4
`define NVM_STALL_WRITE 3'h2
`define NVM_ARM_CYCLES 3'h4
`define NVM_CLK_MHZ 10
`define NVM_WRITE_TIME_US 2500
// ***************************************************
// host register offsets and fields
// ***************************************************
`define HOST_REG_REQ 8'h00
`define HOST_REG_STATUS 8'h04
`define HOST_REG_GIE 8'h08
`define HOST_REG_IRQ_STATUS 8'h0c
`define HOST_REG_IRQ_MASK 8'h10
`define HOST_REQ_OP_BIT 16
`define HOST_EVT_DONE 0
`define HOST_EVT_READY 1
`define HOST_RESP_OKAY 2'h0
`define HOST_RESP_SLVERR 2'h2
`endif

// File: shared/nvm_pkg.sv
package nvm_pkg;
	typedef logic [5:0] io_addr_t;
	typedef logic [8:0] nvm_addr_t;
	typedef logic [7:0] byte_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_READ = 2'b01,
		ST_WRITE = 2'b10
	} nvm_state_t;
endpackage

// File: shared/nvm_io_if.sv
`timescale 1ns/10ps
// ***************************************************
// core-side i/o register port of the nvm controller
// ***************************************************
interface nvm_io_if (
	input wire logic clk,
	input wire logic resetn
);
	nvm_pkg::io_addr_t ioAddr;
	nvm_pkg::byte_t ioWrData;
	logic ioWr;
	logic ioRd;
	nvm_pkg::byte_t ioRdData;
	logic stall;
	logic readyIrq;
	logic globalIrqEnable;
	modport device (
		input clk,
		input resetn,
		input ioAddr,
		input ioWrData,
		input ioWr,
		input ioRd,
		input globalIrqEnable,
		output ioRdData,
		output stall,
		output readyIrq
	);
	modport core (
		input clk,
		input resetn,
		output ioAddr,
		output ioWrData,
		output ioWr,
		output ioRd,
		output globalIrqEnable,
		input ioRdData,
		input stall,
		input readyIrq
	);
endinterface

// File: hdl/nvm_array.sv
`timescale 1ns/10ps
// ***************************************************
// 512 x 8 storage array
// ***************************************************
module nvm_array (
	input wire logic clk,
	input wire logic wrEn,
	input wire nvm_pkg::nvm_addr_t addr,
	input wire nvm_pkg::byte_t wrData,
	output nvm_pkg::byte_t rdData
);
	nvm_pkg::byte_t mem [0:511];

	// contents are not reset: stored data outlives reset
	always_ff @(posedge clk) begin
		if (wrEn) begin
			mem[addr] <= wrData;
		end
	end

	// read is a plain mux, the caller registers it
	assign rdData = mem[addr];
endmodule

// File: hdl/nvm_access_device.sv
`timescale 1ns/10ps
`include "nvm_consts.svh"
module nvm_access_device #(
	parameter int unsigned WRITE_CYCLES = `NVM_WRITE_TIME_US * `NVM_CLK_MHZ
) (
	nvm_io_if.device io,
	output logic writeBusy
);
	// ***************************************************
	// state
	// ***************************************************
	nvm_pkg::byte_t addrLow;
	logic addrHigh;
	nvm_pkg::byte_t dataReg;
	logic readyIrqEnable;
	logic writeArm;
	logic [2:0] armCnt;
	logic [2:0] stallCnt;
	logic [19:0] writeCnt;
	nvm_pkg::nvm_state_t state;
	logic writeStrobe;
	logic readStrobe;
	nvm_pkg::byte_t arrayRd;
	nvm_pkg::nvm_addr_t arrayAddr;
	logic arrayWr;

	// ***************************************************
	// access decode
	// ***************************************************
	function automatic logic ioHit(input nvm_pkg::io_addr_t a, input nvm_pkg::io_addr_t r);
		ioHit = (a == r);
	endfunction

	logic wrLow;
	logic wrHigh;
	logic wrData;
	logic wrCtl;
	logic armReq;
	logic strobeReq;
	logic readReq;
	logic abortReq;
	logic writeDone;

	// register write strobes
	assign wrLow = io.ioWr && ioHit(io.ioAddr, `NVM_IO_ADDR_LOW);
	assign wrHigh = io.ioWr && ioHit(io.ioAddr, `NVM_IO_ADDR_HIGH);
	assign wrData = io.ioWr && ioHit(io.ioAddr, `NVM_IO_DATA);
	assign wrCtl = io.ioWr && ioHit(io.ioAddr, `NVM_IO_CONTROL);

	// arming needs the strobe bit written as zero in the same write
	assign armReq = wrCtl && io.ioWrData[`NVM_CTL_ARM] && !io.ioWrData[`NVM_CTL_WS];

	// strobe counts only if already armed and the array is idle
	assign strobeReq = wrCtl && io.ioWrData[`NVM_CTL_WS] && writeArm
		&& (state == nvm_pkg::ST_IDLE);

	// a read during a write would race the array, so a read strobe is ignored unless idle
	assign readReq = wrCtl && io.ioWrData[`NVM_CTL_RS] && !strobeReq
		&& (state == nvm_pkg::ST_IDLE);

	// touching address or data mid-write kills the write
	assign abortReq = (state == nvm_pkg::ST_WRITE) && (wrLow || wrHigh || wrData);

	// end of the self-timed write
	assign writeDone = (state == nvm_pkg::ST_WRITE) && (writeCnt == 20'h00000);

	// ***************************************************
	// sequencer
	// ***************************************************
	// one state machine for idle, one-cycle read and timed write
	always_ff @(posedge io.clk or negedge io.resetn) begin
		if (!io.resetn) begin
			state <= nvm_pkg::ST_IDLE;
		end else begin
			case (state)
				nvm_pkg::ST_IDLE: begin
					if (strobeReq) begin
						state <= nvm_pkg::ST_WRITE;
					end else if (readReq) begin
						state <= nvm_pkg::ST_READ;
					end
				end
				nvm_pkg::ST_READ: begin
					state <= nvm_pkg::ST_IDLE;
				end
				nvm_pkg::ST_WRITE: begin
					if (abortReq || writeDone) begin
						state <= nvm_pkg::ST_IDLE;
					end
				end
				default: begin
					state <= nvm_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// strobe bits mirror the sequencer, so hardware clears them
	assign writeStrobe = (state == nvm_pkg::ST_WRITE);
	assign readStrobe = (state == nvm_pkg::ST_READ);
	assign writeBusy = writeStrobe;

	// write timer, loaded when the strobe is accepted
	always_ff @(posedge io.clk or negedge io.resetn) begin
		if (!io.resetn) begin
			writeCnt <= 20'h00000;
		end else if (strobeReq) begin
			writeCnt <= 20'(WRITE_CYCLES - 1);
		end else if (writeStrobe && writeCnt != 20'h00000) begin
			writeCnt <= writeCnt - 20'h00001;
		end
	end

	// ***************************************************
	// write arm timeout
	// ***************************************************
	// reload on every arm, drop after four cycles untouched
	always_ff @(posedge io.clk or negedge io.resetn) begin
		if (!io.resetn) begin
			writeArm <= 1'b0;
			armCnt <= 3'h0;
		end else if (armReq) begin
			writeArm <= 1'b1;
			armCnt <= `NVM_ARM_CYCLES - 3'h1;
		end else if (armCnt != 3'h0) begin
			armCnt <= armCnt - 3'h1;
		end else begin
			writeArm <= 1'b0;
		end
	end

	// ***************************************************
	// core stall
	// ***************************************************
	// the core issues nothing while stall is high
	always_ff @(posedge io.clk or negedge io.resetn) begin
		if (!io.resetn) begin
			stallCnt <= 3'h0;
		end else if (readReq) begin
			stallCnt <= `NVM_STALL_READ;
		end else if (strobeReq) begin
			stallCnt <= `NVM_STALL_WRITE;
		end else if (stallCnt != 3'h0) begin
			stallCnt <= stallCnt - 3'h1;
		end
	end

	assign io.stall = (stallCnt != 3'h0);

	// ***************************************************
	// address, data and control registers
	// ***************************************************
	// address pair, upper register holds only bit 8
	always_ff @(posedge io.clk or negedge io.resetn) begin
		if (!io.resetn) begin
			addrLow <= 8'h00;
			addrHigh <= 1'b0;
		end else begin
			if (wrLow) begin
				addrLow <= io.ioWrData;
			end
			if (wrHigh) begin
				addrHigh <= io.ioWrData[0];
			end
		end
	end

	assign arrayAddr = {addrHigh, addrLow};

	// data register: software writes it, a read step refills it
	always_ff @(posedge io.clk or negedge io.resetn) begin
		if (!io.resetn) begin
			dataReg <= 8'h00;
		end else if (readStrobe) begin
			dataReg <= arrayRd;
		end else if (wrData) begin
			dataReg <= io.ioWrData;
		end
	end

	// interrupt enable is plain read/write
	always_ff @(posedge io.clk or negedge io.resetn) begin
		if (!io.resetn) begin
			readyIrqEnable <= 1'b0;
		end else if (wrCtl) begin
			readyIrqEnable <= io.ioWrData[`NVM_CTL_RIE];
		end
	end

	// ***************************************************
	// array and readback
	// ***************************************************
	// commit only at the end of an unaborted write
	assign arrayWr = writeDone && !abortReq;

	nvm_array u_array (
		.clk(io.clk),
		.wrEn(arrayWr),
		.addr(arrayAddr),
		.wrData(dataReg),
		.rdData(arrayRd)
	);

	// registered readback, one cycle after the read request
	always_ff @(posedge io.clk or negedge io.resetn) begin
		if (!io.resetn) begin
			io.ioRdData <= 8'h00;
		end else if (io.ioRd) begin
			if (ioHit(io.ioAddr, `NVM_IO_ADDR_LOW)) begin
				io.ioRdData <= addrLow;
			end else if (ioHit(io.ioAddr, `NVM_IO_ADDR_HIGH)) begin
				io.ioRdData <= {7'h00, addrHigh};
			end else if (ioHit(io.ioAddr, `NVM_IO_DATA)) begin
				io.ioRdData <= dataReg;
			end else if (ioHit(io.ioAddr, `NVM_IO_CONTROL)) begin
				io.ioRdData <= {4'h0, readyIrqEnable, writeArm,
					writeStrobe, readStrobe};
			end else begin
				io.ioRdData <= 8'h00;
			end
		end
	end

	// ***************************************************
	// ready interrupt
	// ***************************************************
	// a level, not a pulse: it stays up while enabled and no write runs
	assign io.readyIrq = readyIrqEnable && io.globalIrqEnable && !writeStrobe;
endmodule

// File: hdl/nvm_core_host.sv
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/10ps
`include "nvm_consts.svh"
// ***************************************************
// core-side end: axi4-lite orders to i/o accesses
// ***************************************************
module nvm_core_host (
	nvm_io_if.core io,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic irq
);
	logic awHeld;
	logic wHeld;
	logic [7:0] awAddr;
	logic [31:0] wData;
	logic [3:0] wStrb;
	logic doWrite;
	logic pending;
	logic opRead;
	logic donePhase;
	logic busy;
	logic readyPrev;
	logic gie;
	nvm_pkg::io_addr_t reqAddr;
	nvm_pkg::byte_t reqData;
	nvm_pkg::byte_t lastRd;
	logic [1:0] irqStatus;
	logic [1:0] irqMask;
	logic [1:0] events;
	logic [1:0] clearBits;

	// ***************************************************
	// axi write channels
	// ***************************************************
	// address and data latched in either order
	assign s_axi_awready = !awHeld && !s_axi_bvalid;
	assign s_axi_wready = !wHeld && !s_axi_bvalid;
	assign doWrite = awHeld && wHeld && !s_axi_bvalid;

	always_ff @(posedge io.clk or negedge io.resetn) begin
		if (!io.resetn) begin
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			awAddr <= 8'h00;
			wData <= 32'h00000000;
			wStrb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `HOST_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld <= 1'b1;
				awAddr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld <= 1'b1;
				wData <= s_axi_wdata;
				wStrb <= s_axi_wstrb;
			end
			if (doWrite) begin
				awHeld <= 1'b0;
				wHeld <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (awAddr > `HOST_REG_IRQ_MASK || awAddr[1:0] != 2'h0)
					? `HOST_RESP_SLVERR : `HOST_RESP_OKAY;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ***************************************************
	// request and control registers
	// ***************************************************
	// a request written while busy is dropped, status shows busy
	always_ff @(posedge io.clk or negedge io.resetn) begin
		if (!io.resetn) begin
			reqData <= 8'h00;
			reqAddr <= 6'h00;
			opRead <= 1'b0;
			gie <= 1'b0;
			irqMask <= 2'h0;
		end else if (doWrite) begin
			if (awAddr == `HOST_REG_REQ && !busy) begin
				if (wStrb[0]) begin
					reqData <= wData[7:0];
				end
				if (wStrb[1]) begin
					reqAddr <= wData[13:8];
				end
				if (wStrb[2]) begin
					opRead <= wData[`HOST_REQ_OP_BIT];
				end
			end
			if (awAddr == `HOST_REG_GIE && wStrb[0]) begin
				gie <= wData[0];
			end
			if (awAddr == `HOST_REG_IRQ_MASK && wStrb[0]) begin
				irqMask <= wData[1:0];
			end
		end
	end

	// ***************************************************
	// i/o access issue
	// ***************************************************
	// one idle cycle between accesses lets a new stall show first
	always_ff @(posedge io.clk or negedge io.resetn) begin
		if (!io.resetn) begin
			pending <= 1'b0;
			io.ioWr <= 1'b0;
			io.ioRd <= 1'b0;
			donePhase <= 1'b0;
			lastRd <= 8'h00;
		end else begin
			donePhase <= io.ioWr || io.ioRd;
			if (donePhase && !opRead) begin
				lastRd <= lastRd;
			end else if (donePhase) begin
				lastRd <= io.ioRdData;
			end
			if (doWrite && awAddr == `HOST_REG_REQ && !busy) begin
				pending <= 1'b1;
			end else if (pending && !io.stall && !io.ioWr && !io.ioRd) begin
				pending <= 1'b0;
				io.ioWr <= !opRead;
				io.ioRd <= opRead;
			end else begin
				io.ioWr <= 1'b0;
				io.ioRd <= 1'b0;
			end
		end
	end

	assign busy = pending || io.ioWr || io.ioRd || donePhase;
	assign io.ioAddr = reqAddr;
	assign io.ioWrData = reqData;
	assign io.globalIrqEnable = gie;

	// ***************************************************
	// interrupt status
	// ***************************************************
	assign events = {io.readyIrq && !readyPrev, donePhase};
	assign clearBits = (doWrite && awAddr == `HOST_REG_IRQ_STATUS && wStrb[0])
		? wData[1:0] : 2'h0;

	// set wins over a write-one clear in the same cycle
	always_ff @(posedge io.clk or negedge io.resetn) begin
		if (!io.resetn) begin
			irqStatus <= 2'h0;
			readyPrev <= 1'b0;
		end else begin
			readyPrev <= io.readyIrq;
			irqStatus <= (irqStatus & ~clearBits) | events;
		end
	end

	assign irq = |(irqStatus & irqMask);

	// ***************************************************
	// axi read channel
	// ***************************************************
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge io.clk or negedge io.resetn) begin
		if (!io.resetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `HOST_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `HOST_RESP_OKAY;
			case (s_axi_araddr)
				`HOST_REG_REQ: s_axi_rdata <= {15'h0000, opRead, 2'h0, reqAddr, reqData};
				`HOST_REG_STATUS: s_axi_rdata <= {22'h000000, io.stall, busy, lastRd};
				`HOST_REG_GIE: s_axi_rdata <= {31'h00000000, gie};
				`HOST_REG_IRQ_STATUS: s_axi_rdata <= {30'h00000000, irqStatus};
				`HOST_REG_IRQ_MASK: s_axi_rdata <= {30'h00000000, irqMask};
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `HOST_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule

// File: testbench/nvm_link_chk.sv
`timescale 1ns/10ps
`include "nvm_consts.svh"
// ***************************************************
// link checker between core end and device end
// ***************************************************
module nvm_link_chk #(
	parameter int unsigned WRITE_CYCLES = 40
) (
	input wire logic clk,
	input wire logic resetn,
	input wire nvm_pkg::io_addr_t ioAddr,
	input wire nvm_pkg::byte_t ioWrData,
	input wire logic ioWr,
	input wire logic ioRd,
	input wire nvm_pkg::byte_t ioRdData,
	input wire logic stall,
	input wire logic readyIrq,
	input wire logic globalIrqEnable,
	input wire logic writeBusy
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	logic ctlWr;
	logic ctlRd;
	logic regWr;
	logic [3:0] sinceArm;
	logic rieBit;
	logic abortHit;
	int unsigned busyLen;
	// decoded link accesses
	assign ctlWr = ioWr && ioAddr == `NVM_IO_CONTROL;
	assign ctlRd = ioRd && ioAddr == `NVM_IO_CONTROL;
	assign regWr = ioWr && ioAddr[5:2] == 4'h7 && ioAddr[1:0] != 2'h0;
	// arm age saturates, so an old arm never looks live again
	// an arm taken at edge E still counts at edge E+4, where the age reads 3
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sinceArm <= 4'hf;
			rieBit <= 1'b0;
		end else begin
			if (ctlWr && ioWrData[`NVM_CTL_ARM] && !ioWrData[`NVM_CTL_WS])
				sinceArm <= 4'h0;
			else if (sinceArm != 4'hf)
				sinceArm <= sinceArm + 4'h1;
			if (ctlWr)
				rieBit <= ioWrData[`NVM_CTL_RIE];
		end
	end
	// length of the running timed write, and whether it was cut short
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			busyLen <= 0;
			abortHit <= 1'b0;
		end else begin
			busyLen <= writeBusy ? busyLen + 1 : 0;
			abortHit <= writeBusy ? (abortHit || regWr) : 1'b0;
		end
	end
	a_read_stall_four: assert property (
		ctlWr && ioWrData[0] && !ioWrData[1] && !writeBusy |=> stall[*4] ##1 !stall)
		else $error("read strobe stall length wrong");
	a_write_stall_two: assert property (
		$rose(writeBusy) |-> stall ##1 stall ##1 !stall)
		else $error("write strobe stall length wrong");
	a_ready_irq_level: assert property (
		readyIrq == (rieBit && globalIrqEnable && !writeBusy))
		else $error("ready interrupt level wrong");
	a_strobe_needs_arm: assert property (
		ctlWr && ioWrData[1] && sinceArm > 4'h3 && !writeBusy |=> !writeBusy)
		else $error("write started without arm");
	a_armed_strobe_writes: assert property (
		ctlWr && ioWrData[1] && sinceArm <= 4'h3 && !writeBusy |=> writeBusy)
		else $error("armed strobe did not start a write");
	a_arm_self_clears: assert property (
		ctlRd && sinceArm > 4'h3 |=> !ioRdData[`NVM_CTL_ARM])
		else $error("write arm still set");
	a_ctl_upper_zero: assert property (
		ctlRd |=> ioRdData[7:4] == 4'h0)
		else $error("control upper bits not zero");
	a_write_full_length: assert property (
		$fell(writeBusy) && !abortHit |-> busyLen == WRITE_CYCLES)
		else $error("timed write length wrong");
	a_write_no_overrun: assert property (
		writeBusy |-> busyLen < WRITE_CYCLES)
		else $error("timed write overran");
	a_abort_ends_write: assert property (
		regWr && writeBusy |=> !writeBusy)
		else $error("register write did not abort write");
endmodule

// File: testbench/test_eeprom_access_controller.sv
`timescale 1ns/10ps
`include "nvm_consts.svh"
// ***************************************************
// bench: axi4-lite orders through the host to the device
// ***************************************************
module test_eeprom_access_controller;
	localparam int unsigned WCYC = 40; // short timed write keeps the run brief
	localparam nvm_pkg::io_addr_t CTL = `NVM_IO_CONTROL;
	localparam nvm_pkg::io_addr_t LOW = `NVM_IO_ADDR_LOW;
	logic clk;
	logic resetn;
	logic [7:0] s_axi_awaddr;
	logic s_axi_awvalid;
	logic s_axi_awready;
	logic [31:0] s_axi_wdata;
	logic s_axi_wvalid;
	logic s_axi_wready;
	logic [1:0] s_axi_bresp;
	logic s_axi_bvalid;
	logic s_axi_bready;
	logic [7:0] s_axi_araddr;
	logic s_axi_arvalid;
	logic s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0] s_axi_rresp;
	logic s_axi_rvalid;
	logic s_axi_rready;
	logic irq;
	logic writeBusy;
	logic rie;
	int errors;
	int comparisons;
	nvm_pkg::nvm_addr_t addrs[4] = '{9'h000, 9'h1ff, 9'h100, 9'h0ff};
	nvm_pkg::byte_t dats[4] = '{8'h5a, 8'ha5, 8'h3c, 8'hc3};
	nvm_io_if io (.clk(clk), .resetn(resetn));
	nvm_access_device #(.WRITE_CYCLES(WCYC)) u_nvm_access_device (.io(io.device),
		.writeBusy(writeBusy));
	nvm_core_host u_nvm_core_host (.io(io.core), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq));
	nvm_link_chk #(.WRITE_CYCLES(WCYC)) u_nvm_link_chk (.clk(clk), .resetn(resetn),
		.ioAddr(io.ioAddr), .ioWrData(io.ioWrData), .ioWr(io.ioWr), .ioRd(io.ioRd),
		.ioRdData(io.ioRdData), .stall(io.stall), .readyIrq(io.readyIrq),
		.globalIrqEnable(io.globalIrqEnable), .writeBusy(writeBusy));
	// 10 MHz clock
	always #50 clk = ~clk;
	// ***************************************************
	// compare and bus tasks
	// ***************************************************
	task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	// handshakes seen at the falling edge hold until the next rising edge
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw;
		logic w;
		logic b;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		b = 1'b0;
		while (!b) begin
			@(negedge clk);
			aw = s_axi_awvalid && s_axi_awready;
			w = s_axi_wvalid && s_axi_wready;
			b = s_axi_bvalid && s_axi_bready;
			r = s_axi_bresp;
			@(posedge clk);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
			if (b) s_axi_bready <= 1'b0;
		end
	endtask
	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar;
		logic rv;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		rv = 1'b0;
		while (!rv) begin
			@(negedge clk);
			ar = s_axi_arvalid && s_axi_arready;
			rv = s_axi_rvalid && s_axi_rready;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge clk);
			if (ar) s_axi_arvalid <= 1'b0;
			if (rv) s_axi_rready <= 1'b0;
		end
	endtask
	// ***************************************************
	// device access tasks
	// ***************************************************
	task automatic io_req(input logic op, input nvm_pkg::io_addr_t a, input nvm_pkg::byte_t d);
		logic [1:0] r;
		axi_write(`HOST_REG_REQ, {15'h0, op, 2'h0, a, d}, r);
	endtask
	// poll until the host is neither busy nor stalled; a hang is left to the watchdog
	task automatic io_done(output logic [31:0] s);
		logic [1:0] r;
		s = 32'h300;
		while (s[9:8] !== 2'h0)
			axi_read(`HOST_REG_STATUS, s, r);
	endtask
	task automatic io_wr(input nvm_pkg::io_addr_t a, input nvm_pkg::byte_t d);
		logic [31:0] s;
		io_req(1'b0, a, d);
		io_done(s);
	endtask
	task automatic io_rd(input nvm_pkg::io_addr_t a, output nvm_pkg::byte_t d);
		logic [31:0] s;
		io_req(1'b1, a, 8'h00);
		io_done(s);
		d = s[7:0];
	endtask
	// arm and strobe go back to back: the arm only lives four cycles
	task automatic start_write(input nvm_pkg::nvm_addr_t a, input nvm_pkg::byte_t d);
		logic [31:0] s;
		io_wr(LOW, a[7:0]);
		io_wr(`NVM_IO_ADDR_HIGH, {7'h0, a[8]});
		io_wr(`NVM_IO_DATA, d);
		io_req(1'b0, CTL, {4'h0, rie, 3'h4});
		io_req(1'b0, CTL, {4'h0, rie, 3'h2});
		io_done(s);
		@(negedge clk);
	endtask
	// looked at off the edge, so the flop that ends the write has settled
	task automatic wait_write();
		while (writeBusy !== 1'b0)
			@(negedge clk);
		@(negedge clk);
	endtask
	task automatic fetch(input nvm_pkg::nvm_addr_t a, output nvm_pkg::byte_t d);
		io_wr(LOW, a[7:0]);
		io_wr(`NVM_IO_ADDR_HIGH, {7'h0, a[8]});
		io_wr(CTL, {4'h0, rie, 3'h1});
		io_rd(`NVM_IO_DATA, d);
	endtask
	task automatic end_test(input string name);
		$display("test %s done, %0d mismatches so far", name, errors);
	endtask
	task automatic give_verdict();
		$display("%0d comparisons, %0d mismatches", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// watchdog, far beyond the thousand or so cycles the tests need
	initial begin
		repeat (40000) @(posedge clk);
		errors++;
		$display("MISMATCH watchdog expected finish seen timeout");
		give_verdict();
	end
	// ***************************************************
	// test sequence
	// ***************************************************
	initial begin
		logic [31:0] v;
		logic [1:0] r;
		nvm_pkg::byte_t b;
		clk = 1'b0;
		resetn = 1'b0;
		rie = 1'b0;
		s_axi_awaddr = 8'h00;
		s_axi_awvalid = 1'b0;
		s_axi_wdata = 32'h0;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_araddr = 8'h00;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		axi_read(`HOST_REG_STATUS, v, r);
		chk_word("status after reset", 32'h0, v);
		chk_resp("status read", `HOST_RESP_OKAY, r);
		axi_read(8'h14, v, r);
		chk_resp("unmapped read", `HOST_RESP_SLVERR, r);
		axi_write(8'h40, 32'h1, r);
		chk_resp("unmapped write", `HOST_RESP_SLVERR, r);
		end_test("bus");
		// both ends of the address space and the high-bit boundary
		for (int i = 0; i < 4; i++) begin
			start_write(addrs[i], dats[i]);
			chk_word("write running", 32'h1, {31'h0, writeBusy});
			wait_write();
		end
		for (int i = 0; i < 4; i++) begin
			fetch(addrs[i], b);
			chk_word("byte read back", {24'h0, dats[i]}, {24'h0, b});
		end
		end_test("store");
		io_wr(LOW, 8'h00);
		io_wr(`NVM_IO_ADDR_HIGH, 8'h01);
		io_wr(`NVM_IO_DATA, 8'h77);
		io_wr(CTL, 8'h04);
		io_rd(CTL, b);
		chk_word("arm self cleared", 32'h0, {24'h0, b});
		io_wr(CTL, 8'h02);
		@(negedge clk);
		chk_word("late strobe", 32'h0, {31'h0, writeBusy});
		io_req(1'b0, CTL, 8'h06);
		io_req(1'b0, CTL, 8'h02);
		io_done(v);
		@(negedge clk);
		chk_word("strobe without arm", 32'h0, {31'h0, writeBusy});
		fetch(9'h100, b);
		chk_word("byte kept", 32'h3c, {24'h0, b});
		io_wr(CTL, 8'hf8);
		io_rd(CTL, b);
		chk_word("control read", 32'h08, {24'h0, b});
		rie = 1'b1;
		end_test("guard");
		axi_write(`HOST_REG_IRQ_MASK, 32'h2, r);
		chk_resp("mask write", `HOST_RESP_OKAY, r);
		axi_write(`HOST_REG_GIE, 32'h1, r);
		@(negedge clk);
		chk_word("ready irq", 32'h1, {31'h0, irq});
		axi_read(`HOST_REG_IRQ_STATUS, v, r);
		chk_word("event status", 32'h3, v);
		axi_write(`HOST_REG_IRQ_STATUS, 32'h3, r);
		@(negedge clk);
		chk_word("irq cleared", 32'h0, {31'h0, irq});
		axi_write(`HOST_REG_GIE, 32'h0, r);
		start_write(9'h0ff, 8'h99);
		axi_write(`HOST_REG_GIE, 32'h1, r);
		@(negedge clk);
		chk_word("ready low in write", 32'h0, {31'h0, io.readyIrq});
		wait_write();
		chk_word("irq after write", 32'h1, {31'h0, irq});
		axi_write(`HOST_REG_IRQ_MASK, 32'h0, r);
		@(negedge clk);
		chk_word("irq masked", 32'h0, {31'h0, irq});
		axi_write(`HOST_REG_GIE, 32'h0, r);
		end_test("interrupt");
		// an address write in mid-write drops the write
		start_write(9'h0ff, 8'h55);
		chk_word("write started", 32'h1, {31'h0, writeBusy});
		io_wr(LOW, 8'hff);
		@(negedge clk);
		chk_word("write aborted", 32'h0, {31'h0, writeBusy});
		fetch(9'h0ff, b);
		chk_word("aborted byte", 32'h99, {24'h0, b});
		end_test("abort");
		give_verdict();
	end
endmodule
